// ===== include/fra_pkg.sv
package fra_pkg;
  // Register byte offsets within the slave window.
  localparam logic [7:0]  ACCESS_OFF   = 8'h00;
  localparam logic [7:0]  KEYREG_OFF   = 8'h04;
  localparam logic [7:0]  STATUS_OFF   = 8'h0c;
  localparam logic [7:0]  PCTL_OFF     = 8'h10;
  // Field positions.
  localparam int          WS_W         = 3;
  localparam int          PRF_BIT      = 8;
  localparam int          ICE_BIT      = 9;
  localparam int          DCE_BIT      = 10;
  localparam int          BUSY_BIT     = 16;
  localparam int          PAR_LSB      = 8;
  localparam int          LOCK_BIT     = 31;
  // Flash geometry: one array read returns one line of four words.
  localparam int          LINE_W       = 128;
  localparam int          TAG_W        = 28;
  localparam int          ICACHE_LINES = 64;
  localparam int          DCACHE_LINES = 8;
  // The user configuration sector occupies exactly one flash line.
  localparam logic [27:0] CFG_LINE     = 28'h1fffc00;
  // Unlock keys, writable mask and reset values.
  localparam logic [31:0] KEY_FIRST    = 32'h45670123;
  localparam logic [31:0] KEY_SECOND   = 32'hcdef89ab;
  localparam logic [31:0] PCTL_WMASK   = 32'h00010307;
  localparam logic [31:0] PCTL_RST     = 32'h00000000;
  localparam logic [2:0]  WS_RST       = 3'h0;
  // Program width encodings.
  localparam logic [1:0]  PAR_X8       = 2'b00;
  localparam logic [1:0]  PAR_X16      = 2'b01;
  localparam logic [1:0]  PAR_X32      = 2'b10;
  localparam logic [1:0]  PAR_X64      = 2'b11;

  typedef enum logic [1:0] {
    KEY_IDLE = 2'b00, KEY_GOT1 = 2'b01, KEY_OPEN = 2'b10, KEY_DEAD = 2'b11
  } fra_key_t;
  typedef enum logic {ENG_IDLE = 1'b0, ENG_READ = 1'b1} fra_eng_t;
  typedef enum logic [1:0] {
    SRC_I = 2'b00, SRC_D = 2'b01, SRC_P = 2'b10
  } fra_src_t;

  // Bytes written per program operation for a width code.
  function automatic logic [3:0] par_bytes(input logic [1:0] code);
    case (code)
      PAR_X64: par_bytes = 4'h8;
      PAR_X32: par_bytes = 4'h4;
      PAR_X16: par_bytes = 4'h2;
      default: par_bytes = 4'h1;
    endcase
  endfunction

  // Select one 32-bit word of a line by address bits 3:2.
  function automatic logic [31:0] word_of(input logic [LINE_W-1:0] line,
                                          input logic [1:0] sel);
    word_of = line[32*sel +: 32];
  endfunction
endpackage

// ===== logic/fra_flash_accel.sv

// Fully associative line cache with a rank-based true LRU.
module fra_cache #(
  parameter int LINES  = 64,
  parameter int TAG_W  = 28,
  parameter int LINE_W = 128
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              en,
  input  wire logic [TAG_W-1:0]  look_tag,
  input  wire logic              touch,
  input  wire logic              fill,
  input  wire logic [TAG_W-1:0]  fill_tag,
  input  wire logic [LINE_W-1:0] fill_data,
  output logic                   hit,
  output logic [LINE_W-1:0]      hit_data
);
  localparam int RW = $clog2(LINES);
  logic [LINES-1:0]  valid;          // Line holds data.
  logic [TAG_W-1:0]  tag   [LINES];  // Line address per entry.
  logic [LINE_W-1:0] data  [LINES];  // Line contents.
  logic [RW-1:0]     rank  [LINES];  // Zero is the least recently used.
  logic [RW-1:0]     hit_idx;        // Entry that matches the lookup.
  logic [RW-1:0]     free_idx;       // Lowest empty entry.
  logic [RW-1:0]     old_idx;        // Entry with rank zero.
  logic              hit_any;        // Some valid entry matches.
  logic              have_free;      // Some entry is still empty.
  wire  [RW-1:0]     victim  = have_free ? free_idx : old_idx;
  wire  [RW-1:0]     use_idx = fill ? victim : hit_idx;
  wire               upd     = fill || (touch && hit);

  assign hit      = en && hit_any;
  assign hit_data = data[hit_idx];

  // Search all entries; the loop runs downward so the lowest index wins.
  always_comb begin
    hit_any   = 1'b0;
    have_free = 1'b0;
    hit_idx   = '0;
    free_idx  = '0;
    old_idx   = '0;
    for (int k = LINES - 1; k >= 0; k--) begin
      if (valid[k] && (tag[k] == look_tag)) begin
        hit_any = 1'b1;
        hit_idx = RW'(k);
      end
      if (!valid[k]) begin
        have_free = 1'b1;
        free_idx  = RW'(k);
      end
      if (rank[k] == '0) begin
        old_idx = RW'(k);
      end
    end
  end

  // Valid bits: a fill takes an empty entry first, else the oldest one.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      valid <= '0;
    end else if (fill) begin
      valid[victim] <= 1'b1;
    end
  end

  // Storage itself needs no reset; valid bits guard it.
  always_ff @(posedge clk) begin
    if (fill) begin
      tag[victim]  <= fill_tag;
      data[victim] <= fill_data;
    end
  end

  // Ranks stay a permutation: the used entry goes to the top and
  // everything above its old rank moves down by one.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int k = 0; k < LINES; k++) begin
        rank[k] <= RW'(k);
      end
    end else if (upd) begin
      for (int k = 0; k < LINES; k++) begin
        if (RW'(k) == use_idx) begin
          rank[k] <= RW'(LINES - 1);
        end else if (rank[k] > rank[use_idx]) begin
          rank[k] <= rank[k] - 1'b1;
        end
      end
    end
  end
endmodule

// Flash read accelerator with register slave and unlock logic.
module fra_flash_accel (
  input  wire logic                      mclk,
  input  wire logic                      rst,
  input  wire logic                      hsel,
  input  wire logic [31:0]               haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic [31:0]               hwdata,
  input  wire logic                      hready,
  output logic                           hreadyout,
  output logic                           hresp,
  output logic [31:0]                    hrdata,
  input  wire logic                      i_req,
  input  wire logic [31:0]               i_addr,
  output logic                           i_ready,
  output logic [31:0]                    i_rdata,
  input  wire logic                      d_req,
  input  wire logic [31:0]               d_addr,
  output logic                           d_ready,
  output logic [31:0]                    d_rdata,
  output logic                           flash_rd,
  output logic [fra_pkg::TAG_W-1:0]      flash_line,
  input  wire logic [fra_pkg::LINE_W-1:0] flash_rdata,
  input  wire logic                      flash_busy,
  output logic [31:0]                    pgm_ctrl,
  output logic [3:0]                     prog_width
);
  import fra_pkg::*;

  // Bus slave state.
  logic       ph_act;      // A data phase is open.
  logic       ph_write;    // Open data phase is a write.
  logic [7:0] ph_off;      // Offset captured in the address phase.
  logic       err_tail;    // First cycle of an error answer; the second follows.
  // Access control state.
  logic [2:0] ws_pend;     // Last written wait-state count.
  logic [2:0] ws_eff;      // Wait-state count in use.
  logic       pf_en;       // Prefetch enable.
  logic       ic_en;       // Instruction cache enable.
  logic       dc_en;       // Data cache enable.
  fra_key_t   key_st;      // Unlock sequence state.
  // Read engine state.
  fra_eng_t   eng;
  fra_src_t   src;         // Owner of the fetch in flight.
  logic [2:0] cnt;         // Remaining wait cycles of the fetch.
  logic [2:0] fetch_ws;    // Wait states the fetch started with.
  logic       cur_valid;
  logic       pf_valid;
  logic [TAG_W-1:0]  cur_tag;
  logic [TAG_W-1:0]  pf_tag;
  logic [LINE_W-1:0] cur_data;  // Line the core is consuming.
  logic [LINE_W-1:0] pf_data;   // Prefetched next line.
  logic              ic_hit;
  logic              dc_hit;
  logic [LINE_W-1:0] ic_data;
  logic [LINE_W-1:0] dc_data;

  // Register slave decode.
  wire bus_take  = hsel && htrans[1] && hready && (hsize == 3'h2);
  wire wr_pctl   = ph_write && (ph_off == PCTL_OFF);
  wire wr_key    = ph_write && (ph_off == KEYREG_OFF);
  wire wr_acc    = ph_write && (ph_off == ACCESS_OFF);
  wire pctl_stall = ph_act && wr_pctl && flash_busy;
  wire key_good1 = (key_st == KEY_IDLE) && (hwdata == KEY_FIRST);
  wire key_good2 = (key_st == KEY_GOT1) && (hwdata == KEY_SECOND);
  wire key_bad   = wr_key && !(key_good1 || key_good2);
  wire ph_done   = ph_act && !pctl_stall;
  wire do_wr     = ph_done && !key_bad;
  wire unlocked  = (key_st == KEY_OPEN);
  wire [31:0] acc_word  = {21'h0, dc_en, ic_en, pf_en, 5'h0, ws_eff};
  wire [31:0] sr_word   = {15'h0, flash_busy, 16'h0};
  wire [31:0] pctl_word = {!unlocked, pgm_ctrl[30:0]};
  wire [31:0] rd_mux    = (ph_off == ACCESS_OFF) ? acc_word :
                          (ph_off == STATUS_OFF) ? sr_word :
                          (ph_off == PCTL_OFF)   ? pctl_word : 32'h0;
  wire fra_key_t next_key = key_good1 ? KEY_GOT1 :
                            key_good2 ? KEY_OPEN : KEY_DEAD;

  // Bus handshake: every word transfer gets one wait cycle, a control write more while flash is busy, so that data
  // and answers come from flops; a bad key answers ERROR in two cycles.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ph_act    <= 1'b0;
      ph_write  <= 1'b0;
      ph_off    <= 8'h0;
      err_tail  <= 1'b0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0;
    end else if (err_tail) begin
      err_tail  <= 1'b0;
      hreadyout <= 1'b1;
    end else if (ph_act) begin
      if (ph_done) begin
        ph_act <= 1'b0;
        hrdata <= ph_write ? 32'h0 : rd_mux;
        if (key_bad) begin
          hresp    <= 1'b1;
          err_tail <= 1'b1;
        end else begin
          hreadyout <= 1'b1;
        end
      end
    end else if (bus_take) begin
      ph_act    <= 1'b1;
      ph_write  <= hwrite;
      ph_off    <= haddr[7:0];
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else if (hreadyout && hresp) begin
      hresp <= 1'b0;
    end
  end

  // Access control register; the new wait count is only applied while
  // no array read is in flight, so a fetch never changes length midway.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ws_pend <= WS_RST;
      ws_eff  <= WS_RST;
      pf_en   <= 1'b0;
      ic_en   <= 1'b0;
      dc_en   <= 1'b0;
    end else begin
      if (do_wr && wr_acc) begin
        ws_pend <= hwdata[WS_W-1:0];
        pf_en   <= hwdata[PRF_BIT];
        ic_en   <= hwdata[ICE_BIT];
        dc_en   <= hwdata[DCE_BIT];
      end
      if (eng == ENG_IDLE) begin
        ws_eff <= ws_pend;
      end
    end
  end

  // Unlock sequence and the program control register.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      key_st     <= KEY_IDLE;
      pgm_ctrl   <= PCTL_RST;
      prog_width <= 4'h1;
    end else begin
      prog_width <= par_bytes(pgm_ctrl[PAR_LSB+1:PAR_LSB]);
      if (ph_done && wr_key && (key_st != KEY_DEAD)) begin
        key_st <= next_key;
      end
      if (do_wr && wr_pctl && unlocked) begin
        pgm_ctrl <= hwdata & PCTL_WMASK;
        if (hwdata[LOCK_BIT]) begin
          key_st <= KEY_IDLE;
        end
      end
    end
  end

  // Read path decode.
  wire [TAG_W-1:0] i_line = i_addr[31:4];
  wire [TAG_W-1:0] d_line = d_addr[31:4];
  wire [TAG_W-1:0] pf_line = cur_tag + 28'h1;
  wire i_cfg    = (i_line == CFG_LINE);
  wire d_cfg    = (d_line == CFG_LINE);
  wire i_pend   = i_req && !i_ready;
  wire d_pend   = d_req && !d_ready;
  wire cur_hit  = cur_valid && (cur_tag == i_line);
  wire pf_hit   = pf_valid && (pf_tag == i_line);
  wire i_hit    = cur_hit || pf_hit || ic_hit;
  wire i_need   = i_pend && !i_hit;
  wire d_need   = d_pend && !dc_hit;
  wire pf_have  = pf_valid && (pf_tag == pf_line);
  wire pf_want  = pf_en && cur_valid && !i_pend && !d_pend && !pf_have;
  wire is_idle  = (eng == ENG_IDLE);
  wire eng_free = is_idle && !flash_busy;
  wire start_d  = eng_free && d_need;
  wire start_i  = eng_free && !d_need && i_need;
  wire start_p  = eng_free && !d_need && !i_need && pf_want;
  wire start    = start_d || start_i || start_p;
  wire fetch_done = (eng == ENG_READ) && (cnt == 3'h0);
  wire fetch_cfg  = (flash_line == CFG_LINE);
  wire ic_fill  = fetch_done && (src == SRC_I) && ic_en &&
                  !fetch_cfg;
  wire dc_fill  = fetch_done && (src == SRC_D) && dc_en && !fetch_cfg;
  wire ic_touch = is_idle && i_pend && !cur_hit && !pf_hit;
  wire dc_touch = is_idle && d_pend;
  wire [LINE_W-1:0] i_hit_line = cur_hit ? cur_data :
                                 pf_hit  ? pf_data : ic_data;
  wire fra_src_t next_src = start_d ? SRC_D : start_i ? SRC_I : SRC_P;
  wire [TAG_W-1:0] next_line = start_d ? d_line :
                               start_i ? i_line : pf_line;

  // Instruction cache of 64 lines and data cache of 8 lines.
  fra_cache #(
    .LINES  (ICACHE_LINES),
    .TAG_W  (TAG_W),
    .LINE_W (LINE_W)
  ) u_icache (
    .clk       (mclk),
    .rst       (rst),
    .en        (ic_en && !i_cfg),
    .look_tag  (i_line),
    .touch     (ic_touch),
    .fill      (ic_fill),
    .fill_tag  (flash_line),
    .fill_data (flash_rdata),
    .hit       (ic_hit),
    .hit_data  (ic_data)
  );
  fra_cache #(
    .LINES  (DCACHE_LINES),
    .TAG_W  (TAG_W),
    .LINE_W (LINE_W)
  ) u_dcache (
    .clk       (mclk),
    .rst       (rst),
    .en        (dc_en && !d_cfg),
    .look_tag  (d_line),
    .touch     (dc_touch),
    .fill      (dc_fill),
    .fill_tag  (flash_line),
    .fill_data (flash_rdata),
    .hit       (dc_hit),
    .hit_data  (dc_data)
  );

  // Read engine: answers hits in the idle state and runs one array read
  // at a time; the read holds for the wait count plus one cycle.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      eng        <= ENG_IDLE;
      src        <= SRC_I;
      cnt        <= 3'h0;
      fetch_ws   <= 3'h0;
      flash_rd   <= 1'b0;
      flash_line <= '0;
      i_ready    <= 1'b0;
      d_ready    <= 1'b0;
      i_rdata    <= 32'h0;
      d_rdata    <= 32'h0;
      cur_valid  <= 1'b0;
      pf_valid   <= 1'b0;
      cur_tag    <= '0;
      pf_tag     <= '0;
      cur_data   <= '0;
      pf_data    <= '0;
    end else begin
      i_ready <= 1'b0;
      d_ready <= 1'b0;
      case (eng)
        ENG_IDLE: begin
          if (i_pend && i_hit) begin
            i_ready <= 1'b1;
            i_rdata <= word_of(i_hit_line, i_addr[3:2]);
            if (pf_hit && !cur_hit) begin
              cur_tag   <= pf_tag;
              cur_data  <= pf_data;
              cur_valid <= 1'b1;
              pf_valid  <= 1'b0;
            end
          end
          if (d_pend && dc_hit) begin
            d_ready <= 1'b1;
            d_rdata <= word_of(dc_data, d_addr[3:2]);
          end
          if (start) begin
            eng        <= ENG_READ;
            src        <= next_src;
            flash_line <= next_line;
            flash_rd   <= 1'b1;
            cnt        <= ws_eff;
            fetch_ws   <= ws_eff;
          end
        end
        ENG_READ: begin
          if (cnt != 3'h0) begin
            cnt <= cnt - 3'h1;
          end else begin
            eng      <= ENG_IDLE;
            flash_rd <= 1'b0;
            case (src)
              SRC_I: begin
                i_ready   <= 1'b1;
                i_rdata   <= word_of(flash_rdata, i_addr[3:2]);
                cur_tag   <= flash_line;
                cur_data  <= flash_rdata;
                cur_valid <= 1'b1;
              end
              SRC_D: begin
                d_ready <= 1'b1;
                d_rdata <= word_of(flash_rdata, d_addr[3:2]);
              end
              default: begin
                pf_tag   <= flash_line;
                pf_data  <= flash_rdata;
                pf_valid <= 1'b1;
              end
            endcase
          end
        end
        default: eng <= ENG_IDLE;
      endcase
    end
  end

  // Helper count of high cycles of the array read strobe.
  logic [3:0] rd_len;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rd_len <= 4'h0;
    end else begin
      rd_len <= flash_rd ? rd_len + 4'h1 : 4'h0;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  chk_read_len: assert property (
    $fell(flash_rd) |-> (rd_len == {1'b0, fetch_ws} + 4'h1))
    else $error("array read length differs from wait count plus one");
  chk_busy_noread: assert property (
    $rose(flash_rd) |-> !$past(flash_busy))
    else $error("array read started while busy");
  chk_data_first: assert property (
    (eng_free && d_need && i_need) |=> (flash_rd && src == SRC_D))
    else $error("instruction fetch beat literal data");
  chk_cfg_nofill: assert property (
    (ic_fill || dc_fill) |-> (flash_line != CFG_LINE))
    else $error("configuration line allocated in cache");
  chk_ihit_fast: assert property (
    (is_idle && i_pend && ic_hit) |=> i_ready ##1 !i_ready)
    else $error("cache hit not answered next cycle");
  chk_badkey_err: assert property (
    (ph_done && key_bad) |=> (hresp && !hreadyout) ##1 (hresp && hreadyout))
    else $error("bad key did not give two-cycle error");
  chk_pctl_stall: assert property (
    pctl_stall |=> !hreadyout)
    else $error("control write finished while busy");
  chk_locked_hold: assert property (
    !unlocked |=> $stable(pgm_ctrl))
    else $error("locked control register changed");
  chk_prefetch_next: assert property (
    ($rose(flash_rd) && src == SRC_P) |-> (flash_line == $past(pf_line)))
    else $error("prefetch fetched a non-sequential line");
  chk_width_x64: assert property (
    (pgm_ctrl[PAR_LSB+1:PAR_LSB] == PAR_X64) |=> (prog_width == 4'h8))
    else $error("width code 11 not eight bytes");
  chk_ws_read: assert property (
    (ph_done && !ph_write && ph_off == ACCESS_OFF) |=>
      (hrdata[2:0] == $past(ws_eff)))
    else $error("wait count readback not effective value");

  cov_bus_clash: cover property (eng_free && d_need && i_need);
  cov_bad_key: cover property (ph_done && key_bad);
  cov_pf_hit: cover property (is_idle && i_pend && pf_hit && !cur_hit);
  cov_ic_hit: cover property (is_idle && i_pend && ic_hit && !cur_hit);
endmodule

// ===== verif/fra_flash_model.sv
// Flash array stand-in: a line is valid only in the last strobe cycle.
module fra_flash_model (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic         flash_rd,
  input  wire logic [27:0]  flash_line,
  input  wire logic [2:0]   ws,
  output logic [127:0]      flash_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  import fra_pkg::*;
  logic [2:0]   cnt;  // Cycles of the current strobe so far.
  logic [127:0] line; // Word k carries its index and the line address.

  assign line = {4'h3, flash_line, 4'h2, flash_line,
                 4'h1, flash_line, 4'h0, flash_line};

  // Count strobe cycles so an early sample sees the wrong data.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt <= 3'h0;
    end else begin
      cnt <= flash_rd ? cnt + 3'h1 : 3'h0;
    end
  end

  // Outside the last cycle the bus shows the inverse, not the old line.
  assign flash_rdata = (flash_rd && cnt == ws) ? line : ~line;
endmodule

// ===== verif/tb_fra_flash_accel.sv
// Bench: register access, fetch timing, caches and unlock sequence.
module tb_fra_flash_accel;
  timeunit 1ns;
  timeprecision 1ps;
  import fra_pkg::*;
  localparam int WS = 2; // Wait states used for all fetches.
  logic         mclk = 0, rst = 1, hsel = 0, hwrite = 0;
  logic         i_req = 0, d_req = 0, flash_busy = 0;
  logic [1:0]   htrans = 2'h0;
  logic [2:0]   hsize = 3'h2;
  logic [31:0]  haddr = 0, hwdata = 0, i_addr = 0, d_addr = 0;
  logic         hreadyout, hresp, i_ready, d_ready, flash_rd;
  logic [31:0]  hrdata, i_rdata, d_rdata, pgm_ctrl;
  logic [27:0]  flash_line;
  logic [127:0] flash_rdata;
  logic [3:0]   prog_width;
  logic [3:0]   pw [4] = '{4'h1, 4'h2, 4'h4, 4'h8}; // Bytes per code.
  int           miscompares = 0, num_checks = 0, cycles = 0, t0, dn, in;

  fra_flash_accel DUT (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .i_req(i_req), .i_addr(i_addr), .i_ready(i_ready),
    .i_rdata(i_rdata), .d_req(d_req), .d_addr(d_addr), .d_ready(d_ready),
    .d_rdata(d_rdata), .flash_rd(flash_rd), .flash_line(flash_line),
    .flash_rdata(flash_rdata), .flash_busy(flash_busy),
    .pgm_ctrl(pgm_ctrl), .prog_width(prog_width));
  fra_flash_model u_flash (.mclk(mclk), .rst(rst), .flash_rd(flash_rd),
    .flash_line(flash_line), .ws(3'(WS)), .flash_rdata(flash_rdata));

  // Free-running clock and a cycle count for stall measurements.
  initial begin
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) cycles <= cycles + 1;

  // Verdict and end of run; also reached when a wait runs out.
  task automatic test_done();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One single AHB word transfer; waits are bounded by a timeout.
  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic er);
    int n;
    @(posedge mclk);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= {24'h0, a}; hwrite <= wr;
    n = 0;
    do begin @(posedge mclk); n++; end while (hreadyout !== 1'b1 && n < 200);
    htrans <= 2'h0; hwdata <= wd;
    do begin @(posedge mclk); n++; end while (hreadyout !== 1'b1 && n < 200);
    rd = hrdata; er = hresp; hsel <= 1'b0;
    if (n >= 200) begin miscompares++; test_done(); end
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] rd; logic er;
    ahb(1'b0, a, 32'h0, rd, er);
    chk("hrdata", e, rd);
  endtask

  task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic e);
    logic [31:0] rd; logic er;
    ahb(1'b1, a, d, rd, er);
    chk("hresp", {31'h0, e}, {31'h0, er});
  endtask

  // The width output is registered one cycle behind the control word,
  // so it is sampled half a cycle after the write has finished.
  task automatic pwc(input logic [3:0] e);
    @(negedge mclk);
    chk("prog_width", {28'h0, e}, {28'h0, prog_width});
  endtask

  // One fetch; ec is the expected cycle count, zero means a long stall.
  task automatic fc(input logic db, input logic [31:0] a, input int ec);
    int n; logic [31:0] d;
    @(posedge mclk);
    if (db) begin d_req <= 1'b1; d_addr <= a; end
    else begin i_req <= 1'b1; i_addr <= a; end
    n = 0;
    do begin @(posedge mclk); n++; end
    while ((db ? d_ready : i_ready) !== 1'b1 && n < 200);
    d = db ? d_rdata : i_rdata;
    d_req <= 1'b0; i_req <= 1'b0;
    if (n >= 200) begin miscompares++; test_done(); end
    chk("rdata", {2'h0, a[3:2], a[31:4]}, d);
    if (ec > 0) chk("cycles", 32'(ec), 32'(n));
    else chk("stalled", 32'h1, {31'h0, n > 10});
  endtask

  // Main sequence; the key errors come last since they lock for good.
  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    rdc(ACCESS_OFF, 32'h0);
    rdc(PCTL_OFF, 32'h80000000);
    wrc(PCTL_OFF, 32'h300, 1'b0);
    pwc(4'h1);
    wrc(ACCESS_OFF, 32'h602, 1'b0);
    rdc(ACCESS_OFF, 32'h602);
    $display("test registers done");
    fc(1'b0, 32'h100, WS + 3);
    fc(1'b0, 32'h104, 2);
    fc(1'b0, 32'h208, WS + 3);
    fc(1'b0, 32'h10c, 2);
    fc(1'b1, 32'h400, WS + 3);
    fc(1'b1, 32'h500, WS + 3);
    fc(1'b1, 32'h404, 2);
    fc(1'b1, 32'h1fffc000, WS + 3);
    fc(1'b1, 32'h600, WS + 3);
    fc(1'b1, 32'h1fffc004, WS + 3);
    // Fill the data cache: the line touched last must outlive the line
    // filled after it, which a plain fill-order policy would not keep.
    for (int k = 0; k < 6; k++) begin
      fc(1'b1, 32'h3000 + 32'(16 * k), WS + 3);
    end
    fc(1'b1, 32'h408, 2);
    fc(1'b1, 32'h508, WS + 3);
    // Both buses miss together; the data bus must be served first.
    @(posedge mclk);
    i_addr <= 32'h800; d_addr <= 32'h900; i_req <= 1'b1; d_req <= 1'b1;
    dn = 0; in = 0;
    for (int n = 1; n < 200 && in == 0; n++) begin
      @(posedge mclk);
      if (d_ready === 1'b1 && dn == 0) begin d_req <= 1'b0; dn = n; end
      if (i_ready === 1'b1) begin i_req <= 1'b0; in = n; end
    end
    if (in == 0) begin miscompares++; test_done(); end
    chk("d first", 32'(WS + 3), 32'(dn));
    chk("i after", 32'h1, {31'h0, in > dn});
    flash_busy <= 1'b1;
    fork
      fc(1'b0, 32'h700, 0);
      begin repeat (12) @(posedge mclk); flash_busy <= 1'b0; end
    join
    // Prefetch on: the next line is read while no request waits.
    wrc(ACCESS_OFF, 32'h702, 1'b0);
    repeat (8) @(posedge mclk);
    fc(1'b0, 32'h710, 2);
    wrc(ACCESS_OFF, 32'h700, 1'b0);
    rdc(ACCESS_OFF, 32'h700);
    $display("test fetch done");
    wrc(KEYREG_OFF, KEY_FIRST, 1'b0);
    wrc(KEYREG_OFF, KEY_SECOND, 1'b0);
    for (int k = 0; k < 4; k++) begin
      wrc(PCTL_OFF, {22'h0, 2'(k), 8'h0}, 1'b0);
      pwc(pw[k]);
    end
    rdc(PCTL_OFF, 32'h300);
    flash_busy <= 1'b1;
    t0 = cycles;
    fork
      wrc(PCTL_OFF, 32'h100, 1'b0);
      begin repeat (12) @(posedge mclk); flash_busy <= 1'b0; end
    join
    chk("stall", 32'h1, {31'h0, cycles - t0 > 12});
    pwc(4'h2);
    wrc(PCTL_OFF, 32'h80000100, 1'b0);
    rdc(PCTL_OFF, 32'h80000100);
    wrc(PCTL_OFF, 32'h300, 1'b0);
    pwc(4'h2);
    wrc(KEYREG_OFF, KEY_FIRST, 1'b0);
    wrc(KEYREG_OFF, KEY_SECOND, 1'b0);
    rdc(PCTL_OFF, 32'h100);
    chk("pgm_ctrl", 32'h100, pgm_ctrl);
    wrc(PCTL_OFF, 32'h80000100, 1'b0);
    wrc(KEYREG_OFF, KEY_SECOND, 1'b1);
    wrc(KEYREG_OFF, KEY_FIRST, 1'b1);
    wrc(KEYREG_OFF, KEY_SECOND, 1'b1);
    wrc(PCTL_OFF, 32'h300, 1'b0);
    pwc(4'h2);
    $display("test unlock done");
    test_done();
  end
endmodule
